// ### ira_increment_adder.sv
// Increment unit: operand select, 18-bit and relocation adders, bus slave
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ira_consts.svh"
module ira_increment_adder (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Instruction word fields
   input wire logic [2:0] curInstrFunc,
   input wire logic [2:0] curInstrMode,
   input wire logic [2:0] curInstrDest,
   input wire ira_pkg::ira_word_t curInstrConst,
   // Source operand registers
   input wire ira_pkg::ira_word_t addrRegSource,
   input wire ira_pkg::ira_word_t indexRegSource,
   input wire ira_pkg::ira_word_t operandRegSource,
   input wire ira_pkg::ira_word_t secondIndexSource,
   // Issue control gates
   input wire logic gateIncrement,
   input wire logic gateResultToStore,
   // Destination register write
   output logic [2:0] destIndex,
   output ira_pkg::ira_word_t destData,
   output logic [59:0] operandRegDestData,
   output logic addrRegDestWe,
   output logic indexRegDestWe,
   output logic operandRegDestWe,
   // Memory controller side
   output ira_pkg::ira_addr_t storageAddress,
   output logic storageAddressValid,
   output ira_pkg::ira_word_t fieldLengthOperand,
   // AXI4-Lite write channels
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ==========================================
   // Helpers

   // Word-aligned register hit
   function automatic logic isReg(input logic [7:0] addr,
                                  input logic [7:0] off);
      return addr[7:2] == off[7:2];
   endfunction : isReg

   // Byte-lane merge of a write
   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int n = 0; n < 4; n++)
      begin
         if (strb[n])
            res[8*n +: 8] = data[8*n +: 8];
      end
      return res;
   endfunction : mergeBytes

   // ==========================================
   // Software registers and stage state
   ira_pkg::ira_addr_t relocBase;
   ira_pkg::ira_word_t fieldLengthLimit;
   ira_pkg::ira_addr_t psHold;
   ira_pkg::ira_addr_t pcHold;
   ira_pkg::ira_word_t incrHold;
   ira_pkg::ira_dest_t s1Dest;
   logic [2:0] s1Index;
   logic eacHold;
   logic s1Gate;
   logic s1Store;

   // ==========================================
   // Operand selection
   ira_pkg::ira_word_t opA;
   ira_pkg::ira_word_t opB;
   wire selAddr = curInstrMode == `IRA_M_ADDR_K ||
                  curInstrMode == `IRA_M_ADDR_SIDX ||
                  curInstrMode == `IRA_M_ADDR_NSIDX;
   wire selOper = curInstrMode == `IRA_M_OPER_K ||
                  curInstrMode == `IRA_M_OPER_SIDX;
   wire selK = curInstrMode == `IRA_M_ADDR_K ||
               curInstrMode == `IRA_M_INDEX_K ||
               curInstrMode == `IRA_M_OPER_K;
   wire selNegSec = curInstrMode == `IRA_M_ADDR_NSIDX ||
                    curInstrMode == `IRA_M_INDEX_NSIDX;
   // Both operands feed both adders in the same cycle
   assign opA = selAddr ? addrRegSource :
                selOper ? operandRegSource : indexRegSource;
   assign opB = selK ? curInstrConst :
                selNegSec ? ~secondIndexSource : secondIndexSource;

   // ==========================================
   // 18-bit adder, complement of B gives difference
   wire [18:0] rawSum = {1'b0, opA} + {1'b0, opB};
   wire endAroundCarry = rawSum[18];
   ira_pkg::ira_word_t incrSum;
   assign incrSum = ira_pkg::ira_ones_add(opA, opB);

   // ==========================================
   // Relocation adder first stage, complemented inputs
   ira_pkg::ira_addr_t nRel;
   ira_pkg::ira_addr_t nA;
   ira_pkg::ira_addr_t nB;
   ira_pkg::ira_addr_t psNow;
   ira_pkg::ira_addr_t pcNow;
   assign nRel = ~relocBase;
   assign nA = ~{4'h0, opA};
   assign nB = ~{4'h0, opB};

   ira_carry_save uCsa (
      .nRel(nRel),
      .nA(nA),
      .nB(nB),
      .partialSumBits(psNow),
      .partialCarryBits(pcNow)
   );

   // Destination decode from low function bits
   ira_pkg::ira_dest_t destSel;
   assign destSel = ira_pkg::ira_dest_t'(curInstrFunc[1:0]);
   wire storeReq = gateResultToStore && destSel == ira_pkg::IRA_DEST_A &&
                   curInstrDest != 3'h0;

   // Holding register, new pair each clock
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         psHold <= 22'h00_0000;
         pcHold <= 22'h00_0000;
         incrHold <= 18'h0_0000;
         eacHold <= 1'b0;
         s1Dest <= ira_pkg::IRA_DEST_NONE;
         s1Index <= 3'h0;
         s1Gate <= 1'b0;
         s1Store <= 1'b0;
      end
      else
      begin
         psHold <= psNow;
         pcHold <= pcNow;
         incrHold <= incrSum;
         eacHold <= endAroundCarry;
         s1Dest <= destSel;
         s1Index <= curInstrDest;
         s1Gate <= gateIncrement;
         s1Store <= storeReq;
      end
   end

   // ==========================================
   // Second stage: the carry never reaches bit 18, it adds at bit 0
   ira_pkg::ira_addr_t corrTerm;
   ira_pkg::ira_addr_t nSum;
   ira_pkg::ira_addr_t relocSum;
   assign corrTerm = eacHold ? `IRA_CORR_EAC : `IRA_CORR_NOEAC;
   assign nSum = psHold + {pcHold[20:0], 1'b0} + corrTerm;
   assign relocSum = ~nSum;

   // Destination writes and sign extension
   wire wrA = s1Gate && s1Dest == ira_pkg::IRA_DEST_A;
   wire wrB = s1Gate && s1Dest == ira_pkg::IRA_DEST_B;
   wire wrX = s1Gate && s1Dest == ira_pkg::IRA_DEST_X;
   wire [59:0] signExt = {{42{incrHold[`IRA_BIT_SIGN]}}, incrHold};

   // Output stage
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         addrRegDestWe <= 1'b0;
         indexRegDestWe <= 1'b0;
         operandRegDestWe <= 1'b0;
         destIndex <= 3'h0;
         destData <= 18'h0_0000;
         operandRegDestData <= 60'h000_0000_0000_0000;
         storageAddress <= 22'h00_0000;
         storageAddressValid <= 1'b0;
         fieldLengthOperand <= 18'h0_0000;
      end
      else
      begin
         addrRegDestWe <= wrA;
         indexRegDestWe <= wrB;
         operandRegDestWe <= wrX;
         if (s1Gate)
         begin
            destIndex <= s1Index;
            destData <= incrHold;
            operandRegDestData <= signExt;
         end
         if (s1Store)
            storageAddress <= relocSum;
         storageAddressValid <= s1Store;
         fieldLengthOperand <= incrHold;
      end
   end

   // ==========================================
   // AXI4-Lite write path
   logic awHeld;
   logic wHeld;
   logic [7:0] awAddrHeld;
   logic [31:0] wDataHeld;
   logic [3:0] wStrbHeld;
   wire awTake = s_axi_awvalid & s_axi_awready;
   wire wTake = s_axi_wvalid & s_axi_wready;
   wire doWrite = awHeld & wHeld & ~s_axi_bvalid;
   wire next_awHeld = awTake | (awHeld & ~doWrite);
   wire next_wHeld = wTake | (wHeld & ~doWrite);
   wire next_bValid = doWrite | (s_axi_bvalid & ~s_axi_bready);
   wire hitReloc = isReg(awAddrHeld, `IRA_OFF_RELOC);
   wire hitLimit = isReg(awAddrHeld, `IRA_OFF_FLIMIT);
   wire wrMapped = hitReloc | hitLimit |
                   isReg(awAddrHeld, `IRA_OFF_LASTADDR) |
                   isReg(awAddrHeld, `IRA_OFF_LASTINCR);
   wire [31:0] relocMerged = mergeBytes({10'h000, relocBase},
                                        wDataHeld, wStrbHeld);
   wire [31:0] limitMerged = mergeBytes({14'h0000, fieldLengthLimit},
                                        wDataHeld, wStrbHeld);

   // Address and data taken in either order, answer after both
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddrHeld <= 8'h00;
         wDataHeld <= 32'h0000_0000;
         wStrbHeld <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `IRA_RESP_OKAY;
      end
      else
      begin
         awHeld <= next_awHeld;
         wHeld <= next_wHeld;
         if (awTake)
            awAddrHeld <= s_axi_awaddr;
         if (wTake)
         begin
            wDataHeld <= s_axi_wdata;
            wStrbHeld <= s_axi_wstrb;
         end
         s_axi_awready <= ~next_awHeld & ~next_bValid;
         s_axi_wready <= ~next_wHeld & ~next_bValid;
         s_axi_bvalid <= next_bValid;
         if (doWrite)
            s_axi_bresp <= wrMapped ? `IRA_RESP_OKAY : `IRA_RESP_DECERR;
      end
   end

   // Writable registers; status words ignore writes
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         relocBase <= `IRA_RST_RELOC;
         fieldLengthLimit <= `IRA_RST_FLIMIT;
      end
      else if (doWrite)
      begin
         if (hitReloc)
            relocBase <= relocMerged[21:0];
         if (hitLimit)
            fieldLengthLimit <= limitMerged[17:0];
      end
   end

   // ==========================================
   // AXI4-Lite read path
   wire overLimit = fieldLengthOperand >= fieldLengthLimit;
   wire arTake = s_axi_arvalid & s_axi_arready;
   wire next_rValid = arTake | (s_axi_rvalid & ~s_axi_rready);
   wire rdReloc = isReg(s_axi_araddr, `IRA_OFF_RELOC);
   wire rdLimit = isReg(s_axi_araddr, `IRA_OFF_FLIMIT);
   wire rdAddr = isReg(s_axi_araddr, `IRA_OFF_LASTADDR);
   wire rdIncr = isReg(s_axi_araddr, `IRA_OFF_LASTINCR);
   wire rdMapped = rdReloc | rdLimit | rdAddr | rdIncr;
   wire [31:0] rdWord = rdReloc ? {10'h000, relocBase} :
                        rdLimit ? {14'h0000, fieldLengthLimit} :
                        rdAddr ? {10'h000, storageAddress} :
                        rdIncr ? {13'h0000, overLimit, fieldLengthOperand} :
                        32'h0000_0000;

   // One read at a time, data captured when address taken
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `IRA_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= ~next_rValid;
         s_axi_rvalid <= next_rValid;
         if (arTake)
         begin
            s_axi_rdata <= rdWord;
            s_axi_rresp <= rdMapped ? `IRA_RESP_OKAY : `IRA_RESP_DECERR;
         end
      end
   end

   // ==========================================
   // Checks
   logic [1:0] warm;
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         warm <= 2'h0;
      else if (!warm[1])
         warm <= warm + 2'h1;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   chk_fl_every_clock: assert property (
      warm[1] |-> fieldLengthOperand ==
         ira_pkg::ira_ones_add($past(opA, 2), $past(opB, 2)))
      else $error("increment output wrong");
   chk_reloc_sum: assert property (
      warm[1] && storageAddressValid |-> storageAddress ==
         22'(ira_pkg::ira_ones_add($past(opA, 2), $past(opB, 2)) +
         $past(relocBase, 2)))
      else $error("relocated address wrong");
   chk_store_gate: assert property (
      warm[1] |-> storageAddressValid == $past(gateResultToStore &&
         curInstrFunc[1:0] == 2'h1 && curInstrDest != 3'h0, 2))
      else $error("store gate mismatch");
   chk_write_gate: assert property (
      addrRegDestWe || indexRegDestWe || operandRegDestWe
         |-> $past(gateIncrement, 2))
      else $error("destination written without gate");
   chk_dest_one_hot: assert property (
      warm[1] && $past(gateIncrement, 2) |->
         (addrRegDestWe == ($past(curInstrFunc[1:0], 2) == 2'h1)) &&
         (indexRegDestWe == ($past(curInstrFunc[1:0], 2) == 2'h2)) &&
         (operandRegDestWe == ($past(curInstrFunc[1:0], 2) == 2'h3)))
      else $error("wrong destination class");
   chk_sign_extend: assert property (
      operandRegDestWe |-> operandRegDestData[59:18] ==
         {42{operandRegDestData[17]}} &&
         operandRegDestData[17:0] == destData)
      else $error("sign extension wrong");
   chk_partial_sum: assert property (
      warm[1] |-> psHold == ($past(~relocBase) ^ ~{4'h0, $past(opA)} ^
         ~{4'h0, $past(opB)}))
      else $error("partial sum wrong");
   chk_partial_carry: assert property (
      warm[1] |-> pcHold == ~(($past(relocBase) & {4'h0, $past(opA)}) |
         ($past(relocBase) & {4'h0, $past(opB)}) |
         ({4'h0, $past(opA)} & {4'h0, $past(opB)})))
      else $error("partial carry wrong");
   chk_mode_select: assert property (
      curInstrMode == `IRA_M_ADDR_NSIDX |->
         opA == addrRegSource && opB == ~secondIndexSource)
      else $error("operand select wrong");
   chk_bvalid_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");

   cov_store: cover property (storageAddressValid && destData[17]);
   cov_back_to_back: cover property (
      storageAddressValid ##1 storageAddressValid);
   cov_x_write: cover property (operandRegDestWe && destData[17]);
   cov_bus_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule : ira_increment_adder

// ### ira_consts.svh
// Offsets, reset values and adder constants of the increment unit
`ifndef IRA_CONSTS_SVH
`define IRA_CONSTS_SVH
// ==========================================
// Register offsets (byte addresses)
`define IRA_OFF_RELOC 8'h00
`define IRA_OFF_FLIMIT 8'h04
`define IRA_OFF_LASTADDR 8'h08
`define IRA_OFF_LASTINCR 8'h0C
// ==========================================
// Reset values
`define IRA_RST_RELOC 22'h00_0000
`define IRA_RST_FLIMIT 18'h3_FFFF
// ==========================================
// Field positions
`define IRA_BIT_OVERLIMIT 18
`define IRA_BIT_SIGN 17
// ==========================================
// Correction terms, complemented domain
`define IRA_CORR_EAC 22'h04_0001
`define IRA_CORR_NOEAC 22'h00_0002
// ==========================================
// Operand selection codes of the mode field
`define IRA_M_ADDR_K 3'h0
`define IRA_M_INDEX_K 3'h1
`define IRA_M_OPER_K 3'h2
`define IRA_M_OPER_SIDX 3'h3
`define IRA_M_ADDR_SIDX 3'h4
`define IRA_M_ADDR_NSIDX 3'h5
`define IRA_M_INDEX_SIDX 3'h6
`define IRA_M_INDEX_NSIDX 3'h7
// ==========================================
// Bus responses
`define IRA_RESP_OKAY 2'h0
`define IRA_RESP_DECERR 2'h3
`endif

// ### ira_pkg.sv
// Types and shared arithmetic of the increment unit
package ira_pkg;
   typedef logic [17:0] ira_word_t;
   typedef logic [21:0] ira_addr_t;
   // Low two function bits map onto these in order
   typedef enum logic [1:0] {IRA_DEST_NONE, IRA_DEST_A, IRA_DEST_B,
                             IRA_DEST_X} ira_dest_t;

   // One's-complement add with end-around carry
   function automatic ira_word_t ira_ones_add(input ira_word_t a,
                                              input ira_word_t b);
      logic [18:0] raw;
      raw = {1'b0, a} + {1'b0, b};
      return raw[17:0] + {17'h0_0000, raw[18]};
   endfunction : ira_ones_add
endpackage : ira_pkg

// ### ira_carry_save.sv
// First stage of the relocation adder: bitwise partial sums and carries
`timescale 1ns/1ps
module ira_carry_save (
   // Complemented operand vectors
   input wire ira_pkg::ira_addr_t nRel,
   input wire ira_pkg::ira_addr_t nA,
   input wire ira_pkg::ira_addr_t nB,
   // Carry-save result
   output wire ira_pkg::ira_addr_t partialSumBits,
   output wire ira_pkg::ira_addr_t partialCarryBits
);
   // Two or more inputs high
   function automatic logic maj3(input logic x, input logic y,
                                 input logic z);
      return (x & y) | (x & z) | (y & z);
   endfunction : maj3

   // ==========================================
   // Per-bit terms
   for (genvar g = 0; g < 22; g++)
   begin : gBit
      assign partialSumBits[g] = nRel[g] ^ nA[g] ^ nB[g];
      assign partialCarryBits[g] = maj3(nRel[g], nA[g], nB[g]);
   end
endmodule : ira_carry_save

// ### ira_mem_partner.sv
// Memory controller stand-in that applies the field length block
`timescale 1ns/1ps
module ira_mem_partner (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Address sender and field length inputs
   input wire logic [21:0] storageAddress,
   input wire logic storageAddressValid,
   input wire logic [17:0] fieldLengthOperand,
   input wire logic [17:0] fieldLengthLimit,
   // Blocked-reference counter and last accepted address
   output logic [15:0] blockCount,
   output logic [21:0] lastAccepted
);
   // Store refs at or past the limit are dropped, others are taken
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         blockCount <= 16'h0000;
         lastAccepted <= 22'h00_0000;
      end
      else if (storageAddressValid)
      begin
         if (fieldLengthOperand >= fieldLengthLimit)
            blockCount <= blockCount + 16'h0001;
         else
            lastAccepted <= storageAddress;
      end
   end
endmodule : ira_mem_partner

// ### increment_relocation_adder_bench.sv
// Self-checking bench for the increment relocation adder
`timescale 1ns/1ps
`include "ira_consts.svh"
module increment_relocation_adder_bench;
   typedef struct {
      logic [17:0] inc;
      logic [21:0] rel;
      logic [1:0] fn;
      logic [2:0] dst;
      logic gi;
      logic gs;
   } ira_exp_t;
   localparam logic [21:0] RELOC = 22'h2A_5F31;
   localparam logic [17:0] LIMIT = 18'h2_0000;
   // ==========================================
   // Signals
   logic clk, resetn, gateIncrement, gateResultToStore;
   logic [2:0] curInstrFunc, curInstrMode, curInstrDest, destIndex, mIdx;
   ira_pkg::ira_word_t curInstrConst, addrRegSource, indexRegSource;
   ira_pkg::ira_word_t operandRegSource, secondIndexSource, destData;
   ira_pkg::ira_word_t fieldLengthOperand, mData;
   logic [59:0] operandRegDestData;
   logic addrRegDestWe, indexRegDestWe, operandRegDestWe;
   logic storageAddressValid;
   ira_pkg::ira_addr_t storageAddress, mStore;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rnd, rd;
   logic awvalid, awready, wvalid, wready, bvalid;
   logic arvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rs;
   logic [15:0] blockCount;
   int fails, n_compared, expBlocked;
   ira_exp_t q[$];

   // ==========================================
   // Design, far side and clock
   ira_increment_adder uut (.clk(clk), .resetn(resetn),
      .curInstrFunc(curInstrFunc), .curInstrMode(curInstrMode),
      .curInstrDest(curInstrDest), .curInstrConst(curInstrConst),
      .addrRegSource(addrRegSource), .indexRegSource(indexRegSource),
      .operandRegSource(operandRegSource),
      .secondIndexSource(secondIndexSource),
      .gateIncrement(gateIncrement), .gateResultToStore(gateResultToStore),
      .destIndex(destIndex), .destData(destData),
      .operandRegDestData(operandRegDestData),
      .addrRegDestWe(addrRegDestWe), .indexRegDestWe(indexRegDestWe),
      .operandRegDestWe(operandRegDestWe), .storageAddress(storageAddress),
      .storageAddressValid(storageAddressValid),
      .fieldLengthOperand(fieldLengthOperand),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(1'b1));
   ira_mem_partner far (.clk(clk), .resetn(resetn),
      .storageAddress(storageAddress),
      .storageAddressValid(storageAddressValid),
      .fieldLengthOperand(fieldLengthOperand), .fieldLengthLimit(LIMIT),
      .blockCount(blockCount), .lastAccepted());
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ==========================================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      for (int i = 0; i < 8; i++)
         s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
      return s;
   endfunction : lfsr
   // Boundary operands (minus zero, zero) mixed with random ones
   function automatic logic [17:0] pickOp(input logic [31:0] s);
      if (s[1:0] == 2'b00)
         return 18'h3_FFFF;
      if (s[1:0] == 2'b01)
         return 18'h0_0000;
      return s[29:12];
   endfunction : pickOp
   function automatic logic [17:0] onesAdd(input logic [17:0] a,
                                           input logic [17:0] b);
      logic [18:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[17:0] + {17'h0_0000, s[18]};
   endfunction : onesAdd
   task automatic check(input string what, input logic [63:0] seen,
                        input logic [63:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic summarize;
      $display("Compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : summarize

   // ==========================================
   // Register bus master
   task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] resp);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (int i = 0; i < 50; i++)
      begin
         @(posedge clk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid)
         begin
            resp = bresp;
            return;
         end
      end
      fails++;
      summarize();
   endtask : axiWrite
   task automatic axiRead(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
      araddr <= a;
      arvalid <= 1'b1;
      for (int i = 0; i < 50; i++)
      begin
         @(posedge clk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid)
         begin
            d = rdata;
            resp = rresp;
            return;
         end
      end
      fails++;
      summarize();
   endtask : axiRead

   // ==========================================
   // Instruction issue and expected results
   task automatic drive(input bit live);
      ira_exp_t e;
      logic [17:0] a, b, x, sk, k, opA, opB;
      logic [2:0] f, m, d;
      logic gi, gs;
      {f, m, d, k} = {curInstrFunc, curInstrMode, curInstrDest, curInstrConst};
      {a, b, x, sk} = {addrRegSource, indexRegSource, operandRegSource,
                       secondIndexSource};
      {gi, gs} = 2'b00;
      if (live)
      begin
         rnd = lfsr(rnd);
         {gs, gi, d, m, f} = rnd[10:0];
         rnd = lfsr(rnd);
         a = pickOp(rnd);
         rnd = lfsr(rnd);
         b = pickOp(rnd);
         rnd = lfsr(rnd);
         x = pickOp(rnd);
         rnd = lfsr(rnd);
         sk = pickOp(rnd);
         rnd = lfsr(rnd);
         k = pickOp(rnd);
      end
      {curInstrFunc, curInstrMode, curInstrDest} <= {f, m, d};
      curInstrConst <= k;
      {addrRegSource, indexRegSource} <= {a, b};
      {operandRegSource, secondIndexSource} <= {x, sk};
      gateIncrement <= gi;
      gateResultToStore <= gs;
      case (m)
         3'h0: {opA, opB} = {a, k};
         3'h1: {opA, opB} = {b, k};
         3'h2: {opA, opB} = {x, k};
         3'h3: {opA, opB} = {x, sk};
         3'h4: {opA, opB} = {a, sk};
         3'h5: {opA, opB} = {a, ~sk};
         3'h6: {opA, opB} = {b, sk};
         default: {opA, opB} = {b, ~sk};
      endcase
      e.inc = onesAdd(opA, opB);
      e.rel = {4'h0, e.inc} + RELOC;
      {e.fn, e.dst, e.gi, e.gs} = {f[1:0], d, gi, gs};
      q.push_back(e);
   endtask : drive
   task automatic compare;
      ira_exp_t e;
      logic sv;
      e = q.pop_front();
      sv = e.gs && e.fn == 2'b01 && e.dst != 3'h0;
      if (e.gi)
         {mData, mIdx} = {e.inc, e.dst};
      if (sv)
      begin
         mStore = e.rel;
         expBlocked += int'(e.inc >= LIMIT);
      end
      check("fieldLength", fieldLengthOperand, e.inc);
      check("weA", addrRegDestWe, e.gi && e.fn == 2'b01);
      check("weB", indexRegDestWe, e.gi && e.fn == 2'b10);
      check("weX", operandRegDestWe, e.gi && e.fn == 2'b11);
      check("destData", destData, mData);
      check("destIndex", destIndex, mIdx);
      check("xData", operandRegDestData, {{42{mData[17]}}, mData});
      check("storeValid", storageAddressValid, sv);
      check("storeAddr", storageAddress, mStore);
   endtask : compare

   // ==========================================
   // Main sequence
   initial
   begin
      {resetn, gateIncrement, gateResultToStore} = 3'b000;
      {curInstrFunc, curInstrMode, curInstrDest, curInstrConst} = '0;
      {addrRegSource, indexRegSource, operandRegSource} = '0;
      secondIndexSource = '0;
      {awaddr, araddr, wdata, awvalid, wvalid, arvalid} = '0;
      {mData, mIdx, mStore} = '0;
      rnd = 32'h0000_001F;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      // Reset values, writes, read-only and unmapped places
      axiRead(`IRA_OFF_RELOC, rd, rs);
      check("relocReset", rd, 32'h0000_0000);
      axiRead(`IRA_OFF_FLIMIT, rd, rs);
      check("limitReset", rd, 32'h0003_FFFF);
      axiWrite(`IRA_OFF_RELOC, {10'h000, RELOC}, rs);
      check("relocResp", rs, `IRA_RESP_OKAY);
      axiRead(`IRA_OFF_RELOC, rd, rs);
      check("reloc", rd, {10'h000, RELOC});
      axiWrite(`IRA_OFF_FLIMIT, {14'h3FFF, LIMIT}, rs);
      axiRead(`IRA_OFF_FLIMIT, rd, rs);
      check("limit", rd, {14'h0000, LIMIT});
      axiWrite(`IRA_OFF_LASTADDR, 32'h1234_5678, rs);
      check("roResp", rs, `IRA_RESP_OKAY);
      axiRead(`IRA_OFF_LASTADDR, rd, rs);
      check("roKept", rd, 32'h0000_0000);
      axiWrite(8'h10, 32'h0000_0001, rs);
      check("badWrResp", rs, `IRA_RESP_DECERR);
      axiRead(8'h10, rd, rs);
      check("badRdResp", rs, `IRA_RESP_DECERR);
      check("badRdData", rd, 32'h0000_0000);
      // Back-to-back instructions, then quiet cycles to drain
      for (int n = 0; n < 404; n++)
      begin
         @(posedge clk);
         drive(n < 400);
         @(negedge clk);
         if (q.size() == 3)
            compare();
      end
      @(posedge clk);
      check("blocked", blockCount, expBlocked);
      axiRead(`IRA_OFF_LASTADDR, rd, rs);
      check("lastAddr", rd, {10'h000, mStore});
      axiRead(`IRA_OFF_LASTINCR, rd, rs);
      check("lastIncr", rd, {13'h0000, q[q.size() - 1].inc >= LIMIT,
                             q[q.size() - 1].inc});
      summarize();
   end
endmodule : increment_relocation_adder_bench
